// file: address_routing_encryption_decode.sv
// Physical address routing, memory type resolution and encryption attribute decode.
// Summary of operation
// - Below low top, low enabled: system memory.
// - Low top to 4 GiB: memory-mapped I/O.
// - 4 GiB to high top, enabled: memory.
// - High top upward: memory-mapped I/O.
// - Limits use bits 51:23 only.
// - Low limit enabled by config bit 20.
// - High limit enabled by config bit 21.
// - Disabled limit routes its range to I/O.
// - Resolve routing with type via allowed combinations.
// - Bit 3 write routing, bit 4 read routing; here the limits drive both, bits 3 and 4 are not used.
// - Flagged pages encrypted out, decrypted in.
// - Flag honoured for 4K, 2M, 1G pages.
// - Flagged table entry fetches next table decrypted.
// - Nonzero removed address bits raise page fault.
// - Range checks use reduced width, flag masked.
// - Encrypted accesses to I/O are ignored.
// - One random boot key, never software visible.
// - Capability words report support and flag position.
// - Encryption only with extension and paging on.
// - Multi-key addresses carry key index, zero clear.
// - Key index sits at and below flag position.
`timescale 1ns/1ps
module address_routing_encryption_decode #(
  parameter int FLAG_POS = 47,
  parameter int REDUCTION = 5,
  parameter int MAX_KEYS = 63
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic MSR_WR_I,
  input wire logic [1:0] MSR_SEL_I,
  input wire logic [63:0] MSR_WDATA_I,
  output logic [63:0] MSR_RDATA_O,
  input wire logic PAE_I,
  input wire logic PAGING_I,
  input wire addr_route_pkg::access_req_t ACC_REQ_I,
  output addr_route_pkg::access_res_t ACC_RES_O,
  output logic [addr_route_pkg::key_idx_width(MAX_KEYS)-1:0] KEY_INDEX_O,
  input wire addr_route_pkg::entry_req_t ENTRY_REQ_I,
  output addr_route_pkg::entry_res_t ENTRY_RES_O,
  output logic [addr_route_pkg::KEY_W-1:0] CIPHER_KEY_O,
  output logic CIPHER_KEY_VALID_O,
  output logic [31:0] CAP_FEATURE_O,
  output logic [31:0] CAP_INFO_O,
  output logic [31:0] CAP_MK_FEATURE_O,
  output logic [31:0] CAP_MK_INFO_O
);
  import addr_route_pkg::*;

  localparam int KIW = key_idx_width(MAX_KEYS);
  localparam int RED_W = PA_W - REDUCTION;

  logic [63:0] low_top_q;
  logic [63:0] high_top_q;
  logic [63:0] sys_cfg_q;
  logic [63:0] rdata_d;
  logic [63:0] rdata_q;
  logic paging_ok;
  logic enc_active;
  logic mk_active;
  logic [PA_W-1:0] addr_mask;
  logic [PA_W-1:0] masked_addr;
  logic [KIW-1:0] key_idx;
  logic to_dram;
  logic enc_wanted;
  logic drop;
  logic rd_dram;
  logic wr_dram;
  access_res_t res_q;
  logic [KIW-1:0] key_idx_q;
  logic [KEY_W-1:0] lfsr_q;
  logic [KEY_W-1:0] key_q;
  logic key_valid_q;
  logic [31:0] cap_feat_q;
  logic [31:0] cap_info_q;
  logic [31:0] cap_mk_feat_q;
  logic [31:0] cap_mk_info_q;

  // Register port: each limit keeps only its address field, the rest reads zero.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      low_top_q <= TOP_RESET;
      high_top_q <= TOP_RESET;
      sys_cfg_q <= CFG_RESET;
    end else if (MSR_WR_I) begin
      case (MSR_SEL_I)
        SEL_LOW_TOP: low_top_q <= MSR_WDATA_I & TOP_FIELD_MASK;
        SEL_HIGH_TOP: high_top_q <= MSR_WDATA_I & TOP_FIELD_MASK;
        SEL_SYS_CFG: sys_cfg_q <= MSR_WDATA_I & CFG_MASK;
        default: sys_cfg_q <= sys_cfg_q;
      endcase
    end
  end

  always_comb begin
    case (MSR_SEL_I)
      SEL_LOW_TOP: rdata_d = low_top_q;
      SEL_HIGH_TOP: rdata_d = high_top_q;
      SEL_SYS_CFG: rdata_d = sys_cfg_q;
      default: rdata_d = 64'h0000_0000_0000_0000;
    endcase
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_q <= 64'h0000_0000_0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign MSR_RDATA_O = rdata_q;

  // Mode decode. Setting both encryption modes is a software error; single-key wins then.
  assign paging_ok = PAE_I && PAGING_I;
  assign enc_active = sys_cfg_q[CFG_ENC_MODE];
  assign mk_active = sys_cfg_q[CFG_MK_MODE] && !sys_cfg_q[CFG_ENC_MODE];

  // Removed upper bits, the flag and the key index never reach the range compare.
  always_comb begin
    addr_mask = '1;
    if (enc_active || mk_active) begin
      for (int i = RED_W; i < PA_W; i++) begin
        addr_mask[i] = 1'b0;
      end
      addr_mask[FLAG_POS] = 1'b0;
    end
    if (mk_active) begin
      for (int i = FLAG_POS - KIW + 1; i <= FLAG_POS; i++) begin
        addr_mask[i] = 1'b0;
      end
    end
  end

  assign masked_addr = ACC_REQ_I.addr & addr_mask;
  assign key_idx = mk_active ? ACC_REQ_I.addr[FLAG_POS -: KIW] : '0;

  range_classify u_range (
    .addr_i(masked_addr),
    .low_top_i(low_top_q),
    .high_top_i(high_top_q),
    .low_en_i(sys_cfg_q[CFG_LOW_TOP_EN]),
    .high_en_i(sys_cfg_q[CFG_HIGH_TOP_EN]),
    .to_dram_o(to_dram)
  );

  // An index of zero means the access is sent in the clear.
  always_comb begin
    if (mk_active) begin
      enc_wanted = key_idx != '0;
    end else begin
      enc_wanted = enc_active && ACC_REQ_I.enc_flag;
    end
  end

  // An encrypted request toward I/O cannot be serviced, so it is dropped, not sent plain.
  assign drop = paging_ok && enc_wanted && !to_dram;

  // The limit drives read and write routing together, as one pair.
  assign rd_dram = to_dram;
  assign wr_dram = to_dram;

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      res_q <= '0;
      key_idx_q <= '0;
    end else begin
      res_q.valid <= ACC_REQ_I.valid;
      res_q.read_to_dram <= rd_dram;
      res_q.write_to_dram <= wr_dram;
      res_q.mem_type <= ACC_REQ_I.mem_type;
      res_q.combo_reserved <= !combo_allowed(rd_dram, wr_dram, ACC_REQ_I.mem_type);
      res_q.encrypt <= ACC_REQ_I.valid && paging_ok && enc_wanted && to_dram;
      res_q.dropped <= ACC_REQ_I.valid && drop;
      res_q.addr <= masked_addr;
      key_idx_q <= (paging_ok && to_dram) ? key_idx : '0;
    end
  end

  assign ACC_RES_O = res_q;
  assign KEY_INDEX_O = key_idx_q;

  entry_check #(
    .FLAG_POS(FLAG_POS),
    .REDUCTION(REDUCTION)
  ) u_entry (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .enc_active_i(enc_active && paging_ok),
    .mk_active_i(mk_active),
    .req_i(ENTRY_REQ_I),
    .res_o(ENTRY_RES_O)
  );

  // Boot key: a free-running shift register sampled once, when an encryption mode is first enabled.
  // The value only goes to the cipher port; no register read path exposes it.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      lfsr_q <= {{(KEY_W-1){1'b0}}, 1'b1};
    end else begin
      lfsr_q <= {lfsr_q[KEY_W-2:0], lfsr_q[KEY_W-1] ^ lfsr_q[KEY_W-3] ^ lfsr_q[KEY_W-28] ^ lfsr_q[KEY_W-30]};
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      key_q <= '0;
      key_valid_q <= 1'b0;
    end else if (!key_valid_q && (enc_active || mk_active)) begin
      key_q <= lfsr_q;
      key_valid_q <= 1'b1;
    end
  end

  assign CIPHER_KEY_O = key_q;
  assign CIPHER_KEY_VALID_O = key_valid_q;

  // Capability words.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      cap_feat_q <= 32'h0000_0000;
      cap_info_q <= 32'h0000_0000;
      cap_mk_feat_q <= 32'h0000_0000;
      cap_mk_info_q <= 32'h0000_0000;
    end else begin
      cap_feat_q <= 32'h0000_0001 << CAP_ENC_BIT;
      cap_info_q <= (32'(FLAG_POS) << CAP_POS_LSB) | (32'(REDUCTION) << CAP_RED_LSB);
      cap_mk_feat_q <= 32'h0000_0001 << CAP_ENC_BIT;
      cap_mk_info_q <= 32'(MAX_KEYS) << CAP_MAXKEY_LSB;
    end
  end

  assign CAP_FEATURE_O = cap_feat_q;
  assign CAP_INFO_O = cap_info_q;
  assign CAP_MK_FEATURE_O = cap_mk_feat_q;
  assign CAP_MK_INFO_O = cap_mk_info_q;

endmodule

// file: addr_route_pkg.sv
// Shared constants, types and helpers for the physical address routing and encryption decode block.
package addr_route_pkg;

  localparam int PA_W = 52;
  localparam int ENTRY_W = 64;
  localparam int KEY_W = 128;

  // Top-of-memory limit field and the 4 GiB boundary.
  localparam int TOP_LSB = 23;
  localparam int TOP_MSB = 51;
  localparam logic [PA_W-1:0] FOUR_GIG = 52'h0_0001_0000_0000;
  localparam logic [63:0] TOP_FIELD_MASK = 64'h000f_ffff_ff80_0000;
  localparam logic [63:0] TOP_RESET = 64'h0000_0000_0000_0000;

  // System configuration register bits kept by this block.
  localparam int CFG_LOW_TOP_EN = 20;
  localparam int CFG_HIGH_TOP_EN = 21;
  localparam int CFG_ENC_MODE = 23;
  localparam int CFG_MK_MODE = 26;
  localparam logic [63:0] CFG_MASK = 64'h0000_0000_04b0_0000;
  localparam logic [63:0] CFG_RESET = 64'h0000_0000_0000_0000;

  // Model-specific register selects.
  localparam logic [1:0] SEL_LOW_TOP = 2'h0;
  localparam logic [1:0] SEL_HIGH_TOP = 2'h1;
  localparam logic [1:0] SEL_SYS_CFG = 2'h2;

  // Memory type attribute layout.
  localparam int ATTR_WR_BIT = 3;
  localparam int ATTR_RD_BIT = 4;
  localparam logic [2:0] MT_UC = 3'h0;
  localparam logic [2:0] MT_WC = 3'h1;
  localparam logic [2:0] MT_WT = 3'h4;
  localparam logic [2:0] MT_WP = 3'h5;
  localparam logic [2:0] MT_WB = 3'h6;

  // Capability word fields.
  localparam int CAP_ENC_BIT = 0;
  localparam int CAP_POS_LSB = 0;
  localparam int CAP_RED_LSB = 6;
  localparam int CAP_MAXKEY_LSB = 0;

  typedef struct packed {
    logic valid;
    logic write;
    logic enc_flag;
    logic [2:0] mem_type;
    logic [PA_W-1:0] addr;
  } access_req_t;

  typedef struct packed {
    logic valid;
    logic read_to_dram;
    logic write_to_dram;
    logic [2:0] mem_type;
    logic combo_reserved;
    logic encrypt;
    logic dropped;
    logic [PA_W-1:0] addr;
  } access_res_t;

  typedef struct packed {
    logic valid;
    logic leaf;
    logic [ENTRY_W-1:0] data;
  } entry_req_t;

  typedef struct packed {
    logic valid;
    logic fault;
    logic page_encrypted;
    logic next_table_decrypt;
  } entry_res_t;

  // Width of the key index field for a given highest key count.
  function automatic int key_idx_width(input int max_keys);
    key_idx_width = $clog2(max_keys + 1);
  endfunction

  // Allowed read/write routing and memory type combinations.
  function automatic logic combo_allowed(input logic rd, input logic wr, input logic [2:0] mt);
    logic ok;
    ok = 1'b0;
    case ({rd, wr})
      2'b00: ok = (mt == MT_UC) || (mt == MT_WC) || (mt == MT_WT) || (mt == MT_WP);
      2'b01: ok = (mt == MT_UC) || (mt == MT_WC);
      2'b10: ok = (mt == MT_UC) || (mt == MT_WP);
      2'b11: ok = (mt == MT_UC) || (mt == MT_WC) || (mt == MT_WT) || (mt == MT_WB);
      default: ok = 1'b0;
    endcase
    combo_allowed = ok;
  endfunction

endpackage

// file: range_classify.sv
// Top-of-memory range classifier for one masked physical address.
`timescale 1ns/1ps
module range_classify (
  input wire logic [addr_route_pkg::PA_W-1:0] addr_i,
  input wire logic [63:0] low_top_i,
  input wire logic [63:0] high_top_i,
  input wire logic low_en_i,
  input wire logic high_en_i,
  output logic to_dram_o
);
  import addr_route_pkg::*;

  logic [PA_W-1:0] low_lim;
  logic [PA_W-1:0] high_lim;
  logic below_4g;

  // Only bits 51:23 of each limit take part in the compare.
  assign low_lim = {low_top_i[TOP_MSB:TOP_LSB], {TOP_LSB{1'b0}}};
  assign high_lim = {high_top_i[TOP_MSB:TOP_LSB], {TOP_LSB{1'b0}}};
  assign below_4g = addr_i < FOUR_GIG;

  always_comb begin
    if (below_4g) begin
      // A disabled limit leaves the whole range as I/O.
      to_dram_o = low_en_i && (addr_i < low_lim);
    end else begin
      to_dram_o = high_en_i && (addr_i < high_lim);
    end
  end

endmodule

// file: entry_check.sv
// Translation entry check for reserved upper address bits and the encrypt flag.
`timescale 1ns/1ps
module entry_check #(
  parameter int FLAG_POS = 47,
  parameter int REDUCTION = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enc_active_i,
  input wire logic mk_active_i,
  input wire addr_route_pkg::entry_req_t req_i,
  output addr_route_pkg::entry_res_t res_o
);
  import addr_route_pkg::*;

  localparam int RED_W = PA_W - REDUCTION;

  logic [ENTRY_W-1:0] rsvd_mask;
  logic flag;
  entry_res_t res_q;

  // Bits removed by the address shrink, except the flag bit itself.
  always_comb begin
    rsvd_mask = '0;
    for (int i = RED_W; i < PA_W; i++) begin
      if (i != FLAG_POS) begin
        rsvd_mask[i] = 1'b1;
      end
    end
  end

  assign flag = req_i.data[FLAG_POS];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_q <= '0;
    end else begin
      res_q.valid <= req_i.valid;
      res_q.fault <= req_i.valid && (enc_active_i || mk_active_i) && |(req_i.data & rsvd_mask);
      // The flag is honoured on any leaf, whatever the page size.
      res_q.page_encrypted <= req_i.valid && enc_active_i && req_i.leaf && flag;
      res_q.next_table_decrypt <= req_i.valid && enc_active_i && !req_i.leaf && flag;
    end
  end

  assign res_o = res_q;

endmodule

// file: are_asserts.sv
// Port assertions for the routing and encryption decode block.
`timescale 1ns/1ps
module are_check (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic MSR_WR_I,
  input wire logic [1:0] MSR_SEL_I,
  input wire logic [63:0] MSR_WDATA_I,
  input wire logic [63:0] MSR_RDATA_O,
  input wire logic PAE_I,
  input wire logic PAGING_I,
  input wire addr_route_pkg::access_req_t ACC_REQ_I,
  input wire addr_route_pkg::access_res_t ACC_RES_O,
  input wire addr_route_pkg::entry_req_t ENTRY_REQ_I,
  input wire addr_route_pkg::entry_res_t ENTRY_RES_O,
  input wire logic [addr_route_pkg::KEY_W-1:0] CIPHER_KEY_O,
  input wire logic CIPHER_KEY_VALID_O,
  input wire logic [31:0] CAP_FEATURE_O
);
  import addr_route_pkg::*;
  logic [63:0] lo_q;
  logic [63:0] hi_q;
  logic [63:0] cfg_q;
  logic [63:0] a;
  logic plain;
  logic dram;
  default clocking dc @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // Limits are shadowed here so routing is judged without trusting the read port.
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      lo_q <= 64'h0;
      hi_q <= 64'h0;
      cfg_q <= 64'h0;
    end else if (MSR_WR_I) begin
      if (MSR_SEL_I == SEL_LOW_TOP) lo_q <= MSR_WDATA_I & TOP_FIELD_MASK;
      if (MSR_SEL_I == SEL_HIGH_TOP) hi_q <= MSR_WDATA_I & TOP_FIELD_MASK;
      if (MSR_SEL_I == SEL_SYS_CFG) cfg_q <= MSR_WDATA_I & CFG_MASK;
    end
  end
  assign a = {12'h0, ACC_REQ_I.addr};
  assign plain = !cfg_q[CFG_ENC_MODE] && !cfg_q[CFG_MK_MODE];
  assign dram = (a < 64'h1_0000_0000) ? (cfg_q[CFG_LOW_TOP_EN] && a < lo_q) : (cfg_q[CFG_HIGH_TOP_EN] && a < hi_q);
  chk_route_exact:
  assert property (ACC_REQ_I.valid && plain |=> ACC_RES_O.read_to_dram == $past(dram)) else $error("route wrong");
  chk_valid_echo:
  assert property (!$past(RST_I) |-> ACC_RES_O.valid == $past(ACC_REQ_I.valid)) else $error("valid lost");
  chk_combo_flag:
  assert property (ACC_REQ_I.valid && ACC_REQ_I.mem_type == MT_WB && plain && !dram |=> ACC_RES_O.combo_reserved)
    else $error("combo not flagged");
  chk_drop_io:
  assert property (ACC_RES_O.dropped |-> !ACC_RES_O.encrypt && !ACC_RES_O.read_to_dram) else $error("bad drop");
  chk_enc_needs:
  assert property (ACC_RES_O.encrypt |-> ACC_RES_O.write_to_dram && $past(PAGING_I) && $past(PAE_I))
    else $error("bad encrypt");
  chk_fault_bits:
  assert property (ENTRY_REQ_I.valid && cfg_q[CFG_ENC_MODE] && PAE_I && PAGING_I && |ENTRY_REQ_I.data[51:48]
    |=> ENTRY_RES_O.fault) else $error("no fault");
  chk_page_flag:
  assert property (ENTRY_REQ_I.valid && ENTRY_REQ_I.leaf && cfg_q[CFG_ENC_MODE] && PAE_I && PAGING_I
    |=> ENTRY_RES_O.page_encrypted == $past(ENTRY_REQ_I.data[47])) else $error("page flag wrong");
  chk_key_hold:
  assert property (CIPHER_KEY_VALID_O |=> CIPHER_KEY_VALID_O && $stable(CIPHER_KEY_O)) else $error("key moved");
  chk_cap_flag:
  assert property (!$past(RST_I) |-> CAP_FEATURE_O[CAP_ENC_BIT]) else $error("cap bit low");
  chk_limit_mask:
  assert property ($past(MSR_SEL_I) == SEL_LOW_TOP |-> (MSR_RDATA_O & ~TOP_FIELD_MASK) == 64'h0)
    else $error("reserved bits read");
endmodule
bind address_routing_encryption_decode are_check are_check_inst (.CLOCK_I, .RST_I, .MSR_WR_I, .MSR_SEL_I,
  .MSR_WDATA_I, .MSR_RDATA_O, .PAE_I, .PAGING_I, .ACC_REQ_I, .ACC_RES_O, .ENTRY_REQ_I, .ENTRY_RES_O, .CIPHER_KEY_O,
  .CIPHER_KEY_VALID_O, .CAP_FEATURE_O);

// file: core_req_model.sv
// Core side request source for the access path.
`timescale 1ns/1ps
module core_req_model (
  input wire logic go_i,
  input wire logic wr_i,
  input wire logic enc_i,
  input wire logic mode_on_i,
  input wire logic [2:0] mt_i,
  input wire logic [addr_route_pkg::PA_W-1:0] addr_i,
  output addr_route_pkg::access_req_t req_o
);
  import addr_route_pkg::*;
  // Pages are marked encrypted only once the mode bit is set, so the flag never leads the enable.
  assign req_o = '{valid: go_i, write: wr_i, enc_flag: enc_i && mode_on_i, mem_type: mt_i, addr: addr_i};
endmodule

// file: test_address_routing_encryption_decode.sv
// Self-checking bench for the routing and encryption decode block.
`timescale 1ns/1ps
module test_address_routing_encryption_decode;
  import addr_route_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic msr_wr = 1'b0;
  logic [1:0] msr_sel = 2'h0;
  logic [63:0] msr_wdata = 64'h0;
  logic [63:0] msr_rdata;
  logic pae = 1'b0;
  logic paging = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic enc = 1'b0;
  logic [2:0] mt = 3'h0;
  logic [PA_W-1:0] addr = 52'h0;
  access_req_t acc_req;
  access_res_t acc_res;
  logic [5:0] key_idx;
  entry_req_t entry_req = '0;
  entry_res_t entry_res;
  logic [127:0] ckey;
  logic ckey_valid;
  logic [31:0] cap_f;
  logic [31:0] cap_i;
  logic [31:0] cap_mf;
  logic [31:0] cap_mi;
  logic [63:0] low_s = 64'h0;
  logic [63:0] high_s = 64'h0;
  logic [63:0] cfg_s = 64'h0;
  logic [63:0] c;
  logic [127:0] key_s = 128'h0;
  int num_errors = 0;
  int compares = 0;
  always #50 clk = ~clk;
  core_req_model core_req_model_inst (.go_i(go), .wr_i(wr), .enc_i(enc), .mode_on_i(cfg_s[CFG_ENC_MODE]),
    .mt_i(mt), .addr_i(addr), .req_o(acc_req));
  address_routing_encryption_decode address_routing_encryption_decode_inst (.CLOCK_I(clk), .RST_I(rst),
    .MSR_WR_I(msr_wr), .MSR_SEL_I(msr_sel), .MSR_WDATA_I(msr_wdata), .MSR_RDATA_O(msr_rdata), .PAE_I(pae),
    .PAGING_I(paging), .ACC_REQ_I(acc_req), .ACC_RES_O(acc_res), .KEY_INDEX_O(key_idx),
    .ENTRY_REQ_I(entry_req), .ENTRY_RES_O(entry_res), .CIPHER_KEY_O(ckey), .CIPHER_KEY_VALID_O(ckey_valid),
    .CAP_FEATURE_O(cap_f), .CAP_INFO_O(cap_i), .CAP_MK_FEATURE_O(cap_mf), .CAP_MK_INFO_O(cap_mi));
  task automatic compare(logic [63:0] got, logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  function automatic logic [PA_W-1:0] exp_addr(logic [PA_W-1:0] a);
    if (cfg_s[CFG_MK_MODE] && !cfg_s[CFG_ENC_MODE]) a[51:42] = 10'h0;
    if (cfg_s[CFG_ENC_MODE]) a[51:47] = 5'h0;
    return a;
  endfunction
  function automatic logic exp_dram(logic [PA_W-1:0] a);
    logic [PA_W-1:0] m;
    m = exp_addr(a);
    if (m < FOUR_GIG) return cfg_s[CFG_LOW_TOP_EN] && {12'h0, m} < low_s;
    return cfg_s[CFG_HIGH_TOP_EN] && {12'h0, m} < high_s;
  endfunction
  function automatic logic [PA_W-1:0] pick();
    logic [PA_W-1:0] v;
    case ($urandom_range(0, 6))
      0: v = low_s[PA_W-1:0];
      1: v = low_s[PA_W-1:0] - 52'h1;
      2: v = FOUR_GIG - 52'h1;
      3: v = FOUR_GIG;
      4: v = high_s[PA_W-1:0];
      5: v = high_s[PA_W-1:0] - 52'h1;
      default: v = PA_W'({$urandom, $urandom});
    endcase
    if ($urandom_range(0, 1) == 1) v[51:42] = 10'($urandom);
    return v;
  endfunction
  task automatic wr_reg(logic [1:0] s, logic [63:0] d);
    @(posedge clk);
    msr_wr <= 1'b1;
    msr_sel <= s;
    msr_wdata <= d;
    @(posedge clk);
    msr_wr <= 1'b0;
    if (s == SEL_LOW_TOP) low_s <= d & TOP_FIELD_MASK;
    if (s == SEL_HIGH_TOP) high_s <= d & TOP_FIELD_MASK;
    if (s == SEL_SYS_CFG) cfg_s <= d & CFG_MASK;
  endtask
  task automatic rd_chk(logic [1:0] s);
    @(posedge clk);
    msr_sel <= s;
    @(posedge clk);
    @(negedge clk);
    compare(msr_rdata, s == 2'h0 ? low_s : s == 2'h1 ? high_s : s == 2'h2 ? cfg_s : 64'h0);
  endtask
  task automatic access(logic w, logic e, logic [2:0] t, logic [PA_W-1:0] a, logic p, logic g);
    logic d;
    logic mk;
    logic [5:0] k;
    logic [31:0] ok_tbl;
    @(posedge clk);
    {go, wr, enc, mt, addr, pae, paging} <= {1'b1, w, e, t, a, p, g};
    d = exp_dram(a);
    mk = cfg_s[CFG_MK_MODE] && !cfg_s[CFG_ENC_MODE];
    k = (mk && p && g && d) ? a[47:42] : 6'h0;
    // Bit {read, write, type} of this table is set where the routing pair and type are allowed.
    ok_tbl = 32'h5321_0333 >> {d, d, t};
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    compare(acc_res.valid, 1'b1);
    compare(acc_res.read_to_dram, d);
    compare(acc_res.write_to_dram, d);
    compare(acc_res.mem_type, t);
    compare(acc_res.combo_reserved, !ok_tbl[0]);
    compare(acc_res.addr, exp_addr(a));
    compare(acc_res.encrypt, p && g && d && (mk ? k != 6'h0 : e && cfg_s[CFG_ENC_MODE]));
    compare(acc_res.dropped, p && g && !d && (mk ? a[47:42] != 6'h0 : e && cfg_s[CFG_ENC_MODE]));
    compare(key_idx, k);
  endtask
  task automatic entry(logic lf);
    logic [63:0] dt;
    dt = {$urandom, $urandom};
    if ($urandom_range(0, 1) == 1) dt[51:48] = 4'h0;
    @(posedge clk);
    entry_req <= '{valid: 1'b1, leaf: lf, data: dt};
    @(posedge clk);
    entry_req.valid <= 1'b0;
    @(negedge clk);
    compare(entry_res.valid, 1'b1);
    compare(entry_res.fault, (cfg_s[CFG_ENC_MODE] ? pae && paging : cfg_s[CFG_MK_MODE]) && dt[51:48] != 4'h0);
    compare(entry_res.page_encrypted, lf && dt[47] && cfg_s[CFG_ENC_MODE] && pae && paging);
    compare(entry_res.next_table_decrypt, !lf && dt[47] && cfg_s[CFG_ENC_MODE] && pae && paging);
  endtask
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h50f67d61));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int s = 0; s < 4; s++) rd_chk(2'(s));
    compare({cap_f, cap_i}, {32'h0000_0001, 20'h0_0000, 6'd5, 6'd47});
    compare({cap_mf, cap_mi}, {32'h0000_0001, 32'h0000_003f});
    wr_reg(2'h3, 64'hffff_ffff_ffff_ffff);
    rd_chk(2'h3);
    for (int i = 0; i < 60; i++) begin
      wr_reg(SEL_LOW_TOP, {$urandom, $urandom} & 64'hfff0_0000_ffff_ffff);
      wr_reg(SEL_HIGH_TOP, {$urandom, $urandom} & 64'hfff0_000f_ffff_ffff);
      c = {$urandom, $urandom};
      c[CFG_ENC_MODE] = (i % 3 == 1);
      c[CFG_MK_MODE] = (i % 3 == 2);
      wr_reg(SEL_SYS_CFG, c);
      for (int s = 0; s < 3; s++) rd_chk(2'(s));
      for (int j = 0; j < 6; j++) access(1'($urandom), 1'($urandom), 3'($urandom), pick(), j != 0, j != 1);
      entry(1'b1);
      entry(1'b0);
      // The key must not move once taken, so a copy from early in the run is checked at the end.
      if (i == 2) key_s = ckey;
    end
    compare(ckey_valid, 1'b1);
    compare(ckey[127:64], key_s[127:64]);
    compare(ckey[63:0], key_s[63:0]);
    give_verdict();
  end
endmodule
